// [rtl/urxdma_ctrl.sv]
// control and termination of the uart receive dma channel, ahb-lite registers
//
// What this block does
// - irq_on_done_enable bit six, reset zero
// - enabled: interrupt when channel_run falls, except on receiver error
// - disabled: no interrupt, flags keep channel_run
// - hardware clears channel_run on finish or error
// - halt on receiver error, or on time-out when enabled
// - halt writes byte count
// - time-out halt interrupts when enabled
// - receiver error halt raises no interrupt
// - status register holds time-out and overflow
// - five-bit time-out reloads per byte, ticks down
// - overflow_flag clears on write one only
// - burst stops at byte limit or error
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module urxdma_ctrl
   import urxdma_pkg::*;
#(
   parameter int BW = BCNT_W
)(
   input wire logic I_CLOCK,
   input wire logic I_RSTN,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic I_HREADY,
   input wire logic [31:0] I_HWDATA,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   input wire logic I_BYTE_DONE,
   input wire logic I_RX_ERROR,
   input wire logic I_OVERRUN,
   input wire logic I_FRAME_TICK,
   input wire logic [BW-1:0] I_BYTE_LIMIT,
   output logic O_RUN,
   output logic O_CONTINUOUS,
   output logic O_BUFFER_SEL,
   output logic [2:0] O_EDB_PTR,
   output logic O_IRQ,
   output logic O_WB_VALID,
   output logic [BW-1:0] O_WB_COUNT
);
   typedef struct packed {
      logic [2:0] edb_ptr;
      logic buf_sel;
      logic cont_sel;
      logic irq_on_done_enable;
      logic run;
      logic ovf_flag;
      logic tmo_flag;
      logic [TMO_W-1:0] tmo_val;
      logic timeout_count_enable;
      logic [BW-1:0] byte_cnt;
      logic wb_valid;
      logic [BW-1:0] wb_count;
      logic irq;
      logic wr_ctrl;
      logic wr_stat;
      logic [31:0] rdata;
   } urxdma_ctrl_s;

   urxdma_ctrl_s s_q;
   urxdma_ctrl_s s_d;

   logic tmo_exp;
   logic addr_ok;
   logic wr_ctrl;
   logic wr_stat;
   logic [7:0] wdat;
   logic run_set;
   logic sw_clr;
   logic active;
   logic ev_err;
   logic ev_ovf;
   logic ev_tmo;
   logic ev_burst;
   logic halt;
   logic [BW-1:0] cnt_next;

   function automatic logic [7:0] ctrl_image(input urxdma_ctrl_s s);
      logic [7:0] v;
      v = 8'h00;
      v[CTRL_EDB_LSB +: 3] = s.edb_ptr;
      v[CTRL_DIR_BIT] = DIR_VALUE;
      v[CTRL_BSEL_BIT] = s.buf_sel;
      v[CTRL_CONT_BIT] = s.cont_sel;
      v[CTRL_INE_BIT] = s.irq_on_done_enable;
      v[CTRL_RUN_BIT] = s.run;
      return v;
   endfunction

   function automatic logic [7:0] stat_image(input urxdma_ctrl_s s);
      logic [7:0] v;
      v = 8'h00;
      v[STAT_OVF_BIT] = s.ovf_flag;
      v[STAT_TFLG_BIT] = s.tmo_flag;
      v[STAT_TMO_LSB +: TMO_W] = s.tmo_val;
      v[STAT_TEN_BIT] = s.timeout_count_enable;
      return v;
   endfunction

   urxdma_tmo #(
      .W(TMO_W)
   ) u_tmo (
      .i_clk(I_CLOCK),
      .i_rstn(I_RSTN),
      .i_enable(s_q.run && s_q.timeout_count_enable),
      .i_load(I_BYTE_DONE),
      .i_value(s_q.tmo_val),
      .i_tick(I_FRAME_TICK),
      .o_expire(tmo_exp)
   );

   // zero-wait slave: writes land in the data phase after the address phase
   assign addr_ok = I_HSEL && I_HREADY && I_HTRANS[1];
   assign wr_ctrl = s_q.wr_ctrl;
   assign wr_stat = s_q.wr_stat;
   assign wdat = I_HWDATA[7:0];
   assign run_set = wr_ctrl && wdat[CTRL_RUN_BIT];
   assign sw_clr = wr_ctrl && !wdat[CTRL_RUN_BIT] && s_q.run;
   // a run written in the same cycle as a termination still counts as running
   assign active = s_q.run || run_set;
   assign ev_err = active && I_RX_ERROR;
   assign ev_ovf = active && I_OVERRUN;
   assign ev_tmo = active && tmo_exp;
   // a byte taken in the starting cycle is the first of the new transfer, not old count plus one
   assign cnt_next = (run_set && !s_q.run) ? BW'(1) : s_q.byte_cnt + BW'(1);
   assign ev_burst = active && !s_q.cont_sel && I_BYTE_DONE && cnt_next == I_BYTE_LIMIT;
   // with interrupts off, flags only report and leave the channel enabled
   assign halt = ev_err || ev_burst || (s_q.irq_on_done_enable && (ev_tmo || ev_ovf));

   always_comb
   begin
      s_d = s_q;
      s_d.wb_valid = 1'b0;
      s_d.irq = 1'b0;
      s_d.wr_ctrl = 1'b0;
      s_d.wr_stat = 1'b0;
      if (wr_ctrl)
      begin
         s_d.edb_ptr = wdat[CTRL_EDB_LSB +: 3];
         s_d.buf_sel = wdat[CTRL_BSEL_BIT];
         s_d.cont_sel = wdat[CTRL_CONT_BIT];
         s_d.irq_on_done_enable = wdat[CTRL_INE_BIT];
         s_d.run = wdat[CTRL_RUN_BIT];
      end
      if (wr_stat)
      begin
         s_d.tmo_val = wdat[STAT_TMO_LSB +: TMO_W];
         s_d.timeout_count_enable = wdat[STAT_TEN_BIT];
         if (wdat[STAT_OVF_BIT])
            s_d.ovf_flag = 1'b0;
         if (wdat[STAT_TFLG_BIT])
            s_d.tmo_flag = 1'b0;
      end
      // set wins over a same-cycle write-one clear
      if (ev_ovf)
         s_d.ovf_flag = 1'b1;
      if (ev_tmo)
         s_d.tmo_flag = 1'b1;
      if (run_set && !s_q.run)
         s_d.byte_cnt = '0;
      if (active && I_BYTE_DONE)
         s_d.byte_cnt = cnt_next;
      if (halt)
      begin
         s_d.run = 1'b0;
         s_d.wb_valid = 1'b1;
         s_d.wb_count = s_d.byte_cnt;
      end
      // receiver errors are reported by the uart itself, not here
      s_d.irq = s_q.irq_on_done_enable && ((halt && !ev_err) || (sw_clr && !halt));
      if (addr_ok)
      begin
         s_d.wr_ctrl = I_HWRITE && I_HADDR == CTRL_ADDR;
         s_d.wr_stat = I_HWRITE && I_HADDR == STAT_ADDR;
         // read image taken from next state so a prior write is visible
         if (I_HWRITE)
            s_d.rdata = 32'h00000000;
         else if (I_HADDR == CTRL_ADDR)
            s_d.rdata = {24'h000000, ctrl_image(s_d)};
         else if (I_HADDR == STAT_ADDR)
            s_d.rdata = {24'h000000, stat_image(s_d)};
         else
            s_d.rdata = 32'h00000000;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         s_q <= '0;
         s_q.edb_ptr <= EDB_RST;
         s_q.tmo_val <= TMO_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign O_HRDATA = s_q.rdata;
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = HRESP_OKAY;
   assign O_RUN = s_q.run;
   assign O_CONTINUOUS = s_q.cont_sel;
   assign O_BUFFER_SEL = s_q.buf_sel;
   assign O_EDB_PTR = s_q.edb_ptr;
   assign O_IRQ = s_q.irq;
   assign O_WB_VALID = s_q.wb_valid;
   assign O_WB_COUNT = s_q.wb_count;

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RSTN);

   sequence s_halt;
      halt && active;
   endsequence
   sequence s_stopped;
      !O_RUN && O_WB_VALID;
   endsequence

   a_run_start: assert property (
      run_set && !halt |=> O_RUN)
      else $error("run write did not start the channel");
   a_err_halts: assert property (
      ev_err |=> s_stopped)
      else $error("receiver error did not halt the channel");
   a_err_quiet: assert property (
      ev_err |=> !O_IRQ)
      else $error("receiver error raised an interrupt");
   a_tmo_irq: assert property (
      ev_tmo && s_q.irq_on_done_enable && !ev_err |=> O_IRQ && !O_RUN)
      else $error("enabled time-out halt gave no interrupt");
   a_flag_keeps: assert property (
      (ev_tmo || ev_ovf) && !s_q.irq_on_done_enable && s_q.run && !ev_err && !ev_burst && !wr_ctrl
      |=> O_RUN && !O_IRQ)
      else $error("flag with interrupts off disturbed the channel");
   a_halt_wb: assert property (
      s_halt |=> s_stopped ##0 O_WB_COUNT == $past(s_d.byte_cnt))
      else $error("halt did not write back the byte count");
   a_fall_irq: assert property (
      $fell(O_RUN) && $past(s_q.irq_on_done_enable) && !$past(ev_err) |-> O_IRQ)
      else $error("falling run gave no interrupt");
   a_ovf_w1c: assert property (
      wr_stat && !ev_ovf && s_q.ovf_flag |=> s_q.ovf_flag == !$past(wdat[STAT_OVF_BIT]))
      else $error("overflow flag write behaved wrongly");
   a_burst_stop: assert property (
      ev_burst |=> !O_RUN ##1 !O_WB_VALID)
      else $error("burst did not stop at the byte limit");
   a_clear_wins: assert property (
      run_set && halt |=> !O_RUN && (O_IRQ == ($past(s_q.irq_on_done_enable) && !$past(ev_err))))
      else $error("run write beat a hardware clear");
   a_stat_read: assert property (
      addr_ok && !I_HWRITE && I_HADDR == STAT_ADDR && !wr_stat
      |=> O_HRDATA[STAT_TMO_LSB +: TMO_W] == s_q.tmo_val)
      else $error("status read lost the time-out value");
   a_soft_stop: assert property (
      sw_clr && !halt && s_q.irq_on_done_enable |=> O_IRQ && !O_RUN && !O_WB_VALID)
      else $error("software stop gave no interrupt");
   a_irq_gated: assert property (
      !s_q.irq_on_done_enable |=> !O_IRQ)
      else $error("interrupt raised while disabled");
   a_tflag_set: assert property (
      ev_tmo |=> s_q.tmo_flag)
      else $error("time-out did not set its flag");
   a_oflag_set: assert property (
      ev_ovf |=> s_q.ovf_flag)
      else $error("overrun did not set its flag");
   a_ine_write: assert property (
      wr_ctrl |=> s_q.irq_on_done_enable == $past(wdat[CTRL_INE_BIT]))
      else $error("interrupt enable write not taken");
endmodule
`default_nettype wire

// [rtl/urxdma_pkg.sv]
// shared constants of the uart receive dma channel control block
package urxdma_pkg;
   // register indices; the bus byte address is four times the index
   localparam logic [15:0] CTRL_IDX = 16'hFFE4;
   localparam logic [15:0] STAT_IDX = 16'hFFE5;
   localparam logic [31:0] CTRL_ADDR = {14'h0000, CTRL_IDX, 2'h0};
   localparam logic [31:0] STAT_ADDR = {14'h0000, STAT_IDX, 2'h0};
   // control register fields
   localparam int CTRL_EDB_LSB = 0;
   localparam int CTRL_DIR_BIT = 3;
   localparam int CTRL_BSEL_BIT = 4;
   localparam int CTRL_CONT_BIT = 5;
   localparam int CTRL_INE_BIT = 6;
   localparam int CTRL_RUN_BIT = 7;
   // status register fields
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_TFLG_BIT = 1;
   localparam int STAT_TMO_LSB = 2;
   localparam int STAT_TEN_BIT = 7;
   // reset values
   localparam logic [2:0] EDB_RST = 3'h0;
   localparam logic [4:0] TMO_RST = 5'h00;
   localparam logic DIR_VALUE = 1'b1;
   // ahb-lite encodings and field widths
   localparam logic HRESP_OKAY = 1'b0;
   localparam int TMO_W = 5;
   localparam int BCNT_W = 8;
endpackage

// [rtl/urxdma_tmo.sv]
// idle time-out down counter, stepped by frame-start pulses
`timescale 1ns/1ps
`default_nettype none
module urxdma_tmo
   import urxdma_pkg::*;
#(
   parameter int W = TMO_W
)(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_enable,
   input wire logic i_load,
   input wire logic [W-1:0] i_value,
   input wire logic i_tick,
   output logic o_expire
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic armed;
      logic expire;
   } urxdma_tmo_s;

   urxdma_tmo_s s_q;
   urxdma_tmo_s s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.expire = 1'b0;
      if (!i_enable)
      begin
         s_d.armed = 1'b0;
         s_d.cnt = '0;
      end
      else if (i_load)
      begin
         // counting starts only after the first byte of a transfer
         s_d.cnt = i_value;
         s_d.armed = 1'b1;
      end
      else if (i_tick && s_q.armed)
      begin
         if (s_q.cnt <= W'(1))
         begin
            s_d.expire = 1'b1;
            s_d.armed = 1'b0;
            s_d.cnt = '0;
         end
         else
         begin
            s_d.cnt = s_q.cnt - W'(1);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign o_expire = s_q.expire;

   a_tmo_after_tick: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_expire |-> $past(i_tick) && $past(i_enable) && !$past(i_load))
      else $error("time-out expired without a frame tick");
   a_tmo_reload: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_enable && i_load |=> !o_expire ##0 s_q.cnt == $past(i_value))
      else $error("byte did not reload the time-out counter");
endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the receive dma channel control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import urxdma_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] limit = 8'h03;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hready, hresp, run, cont, bsel, irq, wbv, bd, er, ov, tk;
   logic [2:0] edb;
   logic [7:0] wbc;
   int fail_count = 0;
   int check_count = 0;
   int irq_n = 0;
   int wb_n = 0;
   always #25 clk = ~clk;
   urxdma_ctrl urxdma_ctrl_i (.I_CLOCK(clk), .I_RSTN(rstn), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HREADY(hready),
      .I_HWDATA(hwdata), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_BYTE_DONE(bd), .I_RX_ERROR(er), .I_OVERRUN(ov), .I_FRAME_TICK(tk),
      .I_BYTE_LIMIT(limit), .O_RUN(run), .O_CONTINUOUS(cont), .O_BUFFER_SEL(bsel),
      .O_EDB_PTR(edb), .O_IRQ(irq), .O_WB_VALID(wbv), .O_WB_COUNT(wbc));
   urxdma_far_model urxdma_far_model_i (.i_clk(clk), .o_byte(bd), .o_err(er), .o_ovr(ov),
      .o_tick(tk));
   // pulses stand one cycle, so count them at every edge
   always @(posedge clk)
   begin
      if (irq === 1'b1)
         irq_n <= irq_n + 1;
      if (wbv === 1'b1)
         wb_n <= wb_n + 1;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            fail_count++;
            finish_test();
         end
         else
            @(posedge clk);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   task automatic ev(input logic [3:0] k);
      urxdma_far_model_i.fire(k);
   endtask
   task automatic cnt(input int i, input int w);
      repeat (4) @(posedge clk);
      chk("irq_pulses", i, irq_n);
      chk("writebacks", w, wb_n);
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc("ctrl_reset", CTRL_ADDR, 32'h08);
      rdc("stat_reset", STAT_ADDR, 32'h00);
      rdc("unmapped", 32'h0000_0100, 32'h00);
      chk("hresp", 32'h0, {31'h0, hresp});
      $display("test reset done");
      wr(CTRL_ADDR, 32'hC0);
      repeat (3) ev(4'h8);
      cnt(1, 1);
      chk("burst_count", 32'h03, {24'h0, wbc});
      rdc("burst_ctrl", CTRL_ADDR, 32'h48);
      wr(CTRL_ADDR, 32'hC0);
      wr(CTRL_ADDR, 32'h40);
      cnt(2, 1);
      $display("test burst done");
      wr(STAT_ADDR, 32'h88);
      wr(CTRL_ADDR, 32'hE0);
      ev(4'h8);
      ev(4'h1);
      ev(4'h1);
      cnt(3, 2);
      chk("tmo_count", 32'h01, {24'h0, wbc});
      rdc("tmo_ctrl", CTRL_ADDR, 32'h68);
      rdc("tmo_stat", STAT_ADDR, 32'h8A);
      wr(STAT_ADDR, 32'h88);
      rdc("tflag_keep", STAT_ADDR, 32'h8A);
      wr(STAT_ADDR, 32'h8A);
      rdc("tflag_clr", STAT_ADDR, 32'h88);
      $display("test timeout done");
      wr(CTRL_ADDR, 32'hA0);
      ev(4'h2);
      cnt(3, 2);
      rdc("ovr_ctrl", CTRL_ADDR, 32'hA8);
      rdc("ovr_stat", STAT_ADDR, 32'h89);
      wr(STAT_ADDR, 32'h88);
      rdc("ovf_keep", STAT_ADDR, 32'h89);
      wr(STAT_ADDR, 32'h89);
      rdc("ovf_clr", STAT_ADDR, 32'h88);
      $display("test overrun done");
      wr(CTRL_ADDR, 32'hE0);
      ev(4'h8);
      ev(4'h4);
      cnt(3, 3);
      chk("err_count", 32'h01, {24'h0, wbc});
      rdc("err_ctrl", CTRL_ADDR, 32'h68);
      rdc("err_stat", STAT_ADDR, 32'h88);
      $display("test rx_error done");
      fork
         wr(CTRL_ADDR, 32'hE0);
         begin
            @(posedge clk);
            ev(4'h2);
         end
      join
      cnt(4, 4);
      chk("race_run", 32'h0, {31'h0, run});
      rdc("race_ctrl", CTRL_ADDR, 32'h68);
      rdc("race_stat", STAT_ADDR, 32'h89);
      $display("test race done");
      wr(CTRL_ADDR, 32'h37);
      rdc("field_ctrl", CTRL_ADDR, 32'h3F);
      chk("edb_pin", 32'h7, {29'h0, edb});
      chk("cont_pin", 32'h1, {31'h0, cont});
      chk("bsel_pin", 32'h1, {31'h0, bsel});
      cnt(4, 4);
      $display("test fields done");
      finish_test();
   end
endmodule
`default_nettype wire

// [verification/urxdma_far_model.sv]
// far side model: uart receiver and frame-start pulse source
`timescale 1ns/1ps
`default_nettype none
module urxdma_far_model (
   input wire logic i_clk,
   output logic o_byte,
   output logic o_err,
   output logic o_ovr,
   output logic o_tick
);
   initial {o_byte, o_err, o_ovr, o_tick} = 4'h0;
   // one-cycle strobe, then a quiet cycle so strobes never merge
   task automatic fire(input logic [3:0] k);
      {o_byte, o_err, o_ovr, o_tick} <= k;
      @(posedge i_clk);
      {o_byte, o_err, o_ovr, o_tick} <= 4'h0;
      @(posedge i_clk);
   endtask
endmodule
`default_nettype wire
